/* File: hdl/acf_pkg.sv */
// constants, field layout and reference decoding for the converter setup word
// assumes one 100 MHz system clock; the setup word arrives on a slow serial link
// Summary of operation
// R1 - source 000: internal reference, 2.5 V buffered
// R2 - source 001: internal reference, 4.096 V buffered
// R3 - source 110: external, reference/buffer/thermometer off
// R4 - 111 external buffered; 100/101 never written
// R5 - scan 10: channel 0..last, thermometer, repeat
// R6 - scan 11: channel 0..last, no thermometer
// R7 - echo bit 0 appends setup word
// R8 - filter bit 0 narrows; host quarters rate
// R9 - channel field binary; four-channel ignores bit 9
// R10 - scan 00 single channel; 01 keeps scanning
// R11 - 14 bits, MSB first, sck rising
// R12 - top bit 1 overwrites, 0 keeps
// R13 - apply at conversion end; incomplete discarded
package acf_pkg;
	localparam int ACF_W = 14;
	localparam int ACF_UPD_BIT = 13;
	localparam int ACF_CH_HI = 9;
	localparam int ACF_CH_LO = 7;
	localparam int ACF_FW_BIT = 6;
	localparam int ACF_REF_HI = 5;
	localparam int ACF_REF_LO = 3;
	localparam int ACF_SCAN_HI = 2;
	localparam int ACF_SCAN_LO = 1;
	localparam int ACF_ECHO_BIT = 0;
	// power-up contents are undefined; the factory preload is used instead
	localparam logic [13:0] ACF_CFG_RST = 14'h3FFF;
	localparam logic [3:0] ACF_CNT_FULL = 4'hE;
	localparam logic [3:0] ACF_CNT_ZERO = 4'h0;
	localparam logic [3:0] ACF_CNT_ONE = 4'h1;
	localparam logic [2:0] ACF_CH_ZERO = 3'h0;
	localparam logic [2:0] ACF_CH_ONE = 3'h1;
	// reference source codes
	localparam logic [2:0] ACF_REF_INT25 = 3'h0;
	localparam logic [2:0] ACF_REF_INT41 = 3'h1;
	localparam logic [2:0] ACF_REF_EXT_T = 3'h2;
	localparam logic [2:0] ACF_REF_EXT_BT = 3'h3;
	localparam logic [2:0] ACF_REF_EXT = 3'h6;
	localparam logic [2:0] ACF_REF_EXT_B = 3'h7;
	// scan mode codes
	localparam logic [1:0] ACF_SCAN_OFF = 2'h0;
	localparam logic [1:0] ACF_SCAN_HOLD = 2'h1;
	localparam logic [1:0] ACF_SCAN_TEMP = 2'h2;
	localparam logic [1:0] ACF_SCAN_LOOP = 2'h3;
	// decoded reference controls: bit positions
	localparam int ACF_RC_INT = 0;
	localparam int ACF_RC_HI = 1;
	localparam int ACF_RC_BUF = 2;
	localparam int ACF_RC_THERM = 3;

	typedef enum logic [2:0] {
		ACF_ST_SINGLE = 3'b001,
		ACF_ST_CHAN = 3'b010,
		ACF_ST_TEMP = 3'b100
	} acf_scan_t;

	// reserved codes fall to the all-off external setting, the least harmful choice
	function automatic logic [3:0] acf_ref_decode(input logic [2:0] code);
		logic [3:0] rc;
		rc = 4'h0;
		case (code)
			ACF_REF_INT25: rc = 4'hD;
			ACF_REF_INT41: rc = 4'hF;
			ACF_REF_EXT_T: rc = 4'h8;
			ACF_REF_EXT_BT: rc = 4'hC;
			ACF_REF_EXT_B: rc = 4'h4;
			default: rc = 4'h0;
		endcase
		return rc;
	endfunction
endpackage

/* File: hdl/acf_ser_if.sv */
// carries the shifted setup word from the serial shifter to the setup control
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface acf_ser_if;
	logic [13:0] word;
	logic complete;
	logic consume;
	modport shifter(output word, output complete, input consume);
	modport ctrl(input word, input complete, output consume);
endinterface

/* File: hdl/acf_shift.sv */
// serial shifter: synchronises the link pins and collects 14 bits on sck rising edges
// assumes sck, sdi and sample_trigger are asynchronous pins; consume comes from clk_sys logic
`timescale 1ns/1ps
module acf_shift
	import acf_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// link pins
	input wire logic sck,
	input wire logic sdi,
	input wire logic sample_trigger,
	// word to control
	acf_ser_if.shifter ser
);
	logic sck_m, sck_s, sck_d, sdi_m, sdi_s, trig_m, trig_s;
	logic [13:0] word;
	logic [3:0] cnt;
	logic [13:0] next_word;
	logic [3:0] next_cnt;
	logic rise;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sck_m <= 1'b0;
			sck_s <= 1'b0;
			sck_d <= 1'b0;
			sdi_m <= 1'b0;
			sdi_s <= 1'b0;
			trig_m <= 1'b0;
			trig_s <= 1'b0;
		end else begin
			sck_m <= sck;
			sck_s <= sck_m;
			sck_d <= sck_s;
			sdi_m <= sdi;
			sdi_s <= sdi_m;
			trig_m <= sample_trigger;
			trig_s <= trig_m;
		end
	end

	// data is ignored while the trigger stands high
	assign rise = sck_s & ~sck_d & ~trig_s;

	always_comb begin
		next_word = word;
		next_cnt = cnt;
		if (ser.consume) begin
			// an edge in the consume cycle starts the next word
			next_cnt = rise ? ACF_CNT_ONE : ACF_CNT_ZERO;
			if (rise)
				next_word = {word[12:0], sdi_s}; // R11
		end else if (rise && cnt != ACF_CNT_FULL) begin
			next_word = {word[12:0], sdi_s}; // R11
			next_cnt = cnt + ACF_CNT_ONE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			word <= 14'h0000;
			cnt <= ACF_CNT_ZERO;
		end else begin
			word <= next_word;
			cnt <= next_cnt;
		end
	end

	assign ser.word = word;
	assign ser.complete = (cnt == ACF_CNT_FULL);
endmodule

/* File: hdl/acf_top.sv */
// setup word control: stores the setup, decodes reference, filter, echo and channel scan
// assumes conv_done is a one-cycle pulse on clk_sys from the conversion core
`timescale 1ns/1ps
module acf_top
	import acf_pkg::*;
#(
	parameter bit EIGHT_CH = 1'b1
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// serial link pins
	input wire logic sck,
	input wire logic sdi,
	input wire logic sample_trigger,
	// conversion core
	input wire logic conv_done,
	// channel and scan
	output logic [2:0] channel_number_select,
	output logic temp_convert,
	// analog controls
	output logic filter_narrow,
	output logic ref_int_en,
	output logic ref_hi_level,
	output logic ref_buf_en,
	output logic thermo_en,
	// setup echo
	output logic setup_echo_en,
	output logic [13:0] converter_setup_word
);
	acf_ser_if ser ();
	acf_scan_t state, next_state;
	logic [13:0] next_cfg;
	logic [2:0] next_ch;
	logic [3:0] next_rc;
	logic consume;
	logic apply;
	logic restart;
	logic [1:0] mode;
	logic [2:0] last;

	acf_shift u_shift (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.sck(sck),
		.sdi(sdi),
		.sample_trigger(sample_trigger),
		.ser(ser)
	);

	// four-channel part has no bit 9
	function automatic logic [2:0] chan_mask(input logic [2:0] f);
		return EIGHT_CH ? f : {1'b0, f[1:0]}; // R9
	endfunction

	// every conversion end closes the word window, complete or not
	assign consume = conv_done; // R13
	assign ser.consume = consume;
	assign apply = conv_done && ser.complete && ser.word[ACF_UPD_BIT]; // R12 R13

	always_comb begin
		next_cfg = apply ? ser.word : converter_setup_word;
		mode = next_cfg[ACF_SCAN_HI:ACF_SCAN_LO];
		last = chan_mask(next_cfg[ACF_CH_HI:ACF_CH_LO]);
		// changing the last channel outside hold mode, or leaving single mode, starts the scan over
		restart = apply && (ser.word[ACF_CH_HI:ACF_CH_LO] != converter_setup_word[ACF_CH_HI:ACF_CH_LO]);
		next_state = state;
		next_ch = channel_number_select;
		if (conv_done) begin
			case (mode)
				ACF_SCAN_OFF: begin
					next_state = ACF_ST_SINGLE; // R10
					next_ch = last;
				end
				default: begin
					if (mode != ACF_SCAN_HOLD && restart) begin
						next_state = ACF_ST_CHAN;
						next_ch = ACF_CH_ZERO;
					end else begin
						case (state)
							ACF_ST_SINGLE: begin
								next_state = ACF_ST_CHAN;
								next_ch = ACF_CH_ZERO;
							end
							ACF_ST_CHAN: begin
								if (channel_number_select >= last) begin
									next_ch = ACF_CH_ZERO;
									if (mode == ACF_SCAN_TEMP)
										next_state = ACF_ST_TEMP; // R5
									else
										next_state = ACF_ST_CHAN; // R6 R10
								end else begin
									next_ch = channel_number_select + ACF_CH_ONE;
								end
							end
							ACF_ST_TEMP: begin
								next_state = ACF_ST_CHAN; // R5
								next_ch = ACF_CH_ZERO;
							end
							default: begin
								next_state = ACF_ST_SINGLE;
								next_ch = ACF_CH_ZERO;
							end
						endcase
					end
				end
			endcase
		end
		next_rc = acf_ref_decode(next_cfg[ACF_REF_HI:ACF_REF_LO]); // R1 R2 R3 R4
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			converter_setup_word <= ACF_CFG_RST;
			state <= ACF_ST_SINGLE;
			channel_number_select <= ACF_CH_ZERO;
			temp_convert <= 1'b0;
			filter_narrow <= 1'b0;
			ref_int_en <= 1'b0;
			ref_hi_level <= 1'b0;
			ref_buf_en <= 1'b1;
			thermo_en <= 1'b0;
			setup_echo_en <= 1'b0;
		end else begin
			converter_setup_word <= next_cfg;
			state <= next_state;
			channel_number_select <= next_ch;
			temp_convert <= (next_state == ACF_ST_TEMP);
			filter_narrow <= ~next_cfg[ACF_FW_BIT]; // R8
			ref_int_en <= next_rc[ACF_RC_INT];
			ref_hi_level <= next_rc[ACF_RC_HI];
			ref_buf_en <= next_rc[ACF_RC_BUF];
			thermo_en <= next_rc[ACF_RC_THERM];
			setup_echo_en <= ~next_cfg[ACF_ECHO_BIT]; // R7
		end
	end

	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	update_keep_a: assert property (conv_done && ser.complete && !ser.word[ACF_UPD_BIT]
		|=> converter_setup_word == $past(converter_setup_word)) // R12
		else $error("setup changed with update bit clear");
	update_take_a: assert property (conv_done && ser.complete && ser.word[ACF_UPD_BIT]
		|=> converter_setup_word == $past(ser.word)) // R13
		else $error("complete word not applied at conversion end");
	partial_drop_a: assert property (conv_done && !ser.complete
		|=> converter_setup_word == $past(converter_setup_word) && !ser.complete) // R13
		else $error("incomplete word not discarded");
	no_early_a: assert property (!conv_done |=> $stable(converter_setup_word)) // R13
		else $error("setup changed outside conversion end");
	ref_low_a: assert property (converter_setup_word[ACF_REF_HI:ACF_REF_LO] == ACF_REF_INT25
		|-> ref_int_en && !ref_hi_level && ref_buf_en) // R1
		else $error("2.5 V internal reference not selected");
	ref_high_a: assert property (converter_setup_word[ACF_REF_HI:ACF_REF_LO] == ACF_REF_INT41
		|-> ref_int_en && ref_hi_level && ref_buf_en) // R2
		else $error("4.096 V internal reference not selected");
	ref_ext_a: assert property (converter_setup_word[ACF_REF_HI:ACF_REF_LO] == ACF_REF_EXT
		|-> !ref_int_en && !ref_buf_en && !thermo_en) // R3
		else $error("external reference leaves internal parts on");
	ref_extbuf_a: assert property (converter_setup_word[ACF_REF_HI:ACF_REF_LO] == ACF_REF_EXT_B
		|-> !ref_int_en && ref_buf_en && !thermo_en) // R4
		else $error("external buffered reference wrong");
	scan_temp_a: assert property (conv_done && state == ACF_ST_TEMP
		&& converter_setup_word[ACF_SCAN_HI:ACF_SCAN_LO] == ACF_SCAN_TEMP && !apply
		|=> channel_number_select == ACF_CH_ZERO && !temp_convert) // R5
		else $error("scan does not return to channel 0 after thermometer");
	scan_loop_a: assert property (converter_setup_word[ACF_SCAN_HI:ACF_SCAN_LO] == ACF_SCAN_LOOP
		|-> !temp_convert) // R6
		else $error("thermometer converted in loop scan");
	echo_sel_a: assert property (setup_echo_en == !converter_setup_word[ACF_ECHO_BIT]) // R7
		else $error("echo enable does not follow setup");
	filter_sel_a: assert property (filter_narrow == !converter_setup_word[ACF_FW_BIT]) // R8
		else $error("filter width does not follow setup");
	chan_range_a: assert property (!EIGHT_CH |-> !channel_number_select[2]) // R9
		else $error("four-channel part selects channel above 3");
	single_ch_a: assert property (conv_done && next_cfg[ACF_SCAN_HI:ACF_SCAN_LO] == ACF_SCAN_OFF
		|=> channel_number_select == chan_mask(converter_setup_word[ACF_CH_HI:ACF_CH_LO])) // R10
		else $error("single mode does not convert selected channel");

	apply_c: cover property (apply);
	temp_c: cover property (temp_convert ##[1:200] !temp_convert);
	drop_c: cover property (conv_done && !ser.complete && !$stable(ser.word));
	wrap_c: cover property (state == ACF_ST_CHAN && conv_done && channel_number_select == 3'h7);
endmodule

/* File: tb/acf_host.sv */
// host model: shifts setup words into the converter over the serial link
// assumes the caller paces conversions; sck idles low and stands still between frames
`timescale 1ns/1ps
module acf_host (
	// link pins
	output logic sck,
	output logic sdi,
	output logic sample_trigger
);
	initial begin
		sck = 1'b0;
		sdi = 1'b0;
		sample_trigger = 1'b0;
	end
	// sends the top nbits of w; trig high models a frame sent while a conversion starts
	task automatic send(input logic [13:0] w, input int nbits, input logic trig);
		sample_trigger = trig;
		for (int i = 13; i > 13 - nbits; i--) begin
			sdi = w[i];
			#40 sck = 1'b1;
			#40 sck = 1'b0;
		end
		// released data line shows the inverse, so a stale bit can never pass for a good one
		sdi = ~sdi;
		sample_trigger = 1'b0;
	endtask
endmodule

/* File: tb/tb_adc_config_field_decode.sv */
// testbench for the setup word decoder: table of full words, then refusals and scanning
// assumes acf_host as the link master and conv_done pulses made here
`timescale 1ns/1ps
module tb_adc_config_field_decode;
	import acf_pkg::*;
	typedef struct packed {
		logic [13:0] w;
		logic [9:0] e;
	} acf_row_t;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic conv_done = 1'b0;
	logic sck, sdi, sample_trigger, temp_convert, filter_narrow, ref_int_en, ref_hi_level;
	logic ref_buf_en, thermo_en, setup_echo_en;
	logic [2:0] channel_number_select;
	logic [2:0] ch_four;
	logic [13:0] converter_setup_word;
	logic [9:0] obs;
	int n_mismatch = 0;
	int total_checks = 0;
	// reference codes 100 and 101 are never sent
	acf_row_t rows [6] = '{'{14'h3EC0, 10'h297}, '{14'h3F89, 10'h3BE}, '{14'h3C50, 10'h003},
		'{14'h3D99, 10'h1A6}, '{14'h3F71, 10'h300}, '{14'h3CB8, 10'h0A5}};
	assign obs = {channel_number_select, temp_convert, filter_narrow, ref_int_en, ref_hi_level, ref_buf_en,
		thermo_en, setup_echo_en};
	always #5 clk_sys = ~clk_sys;
	acf_host host (.sck(sck), .sdi(sdi), .sample_trigger(sample_trigger));
	acf_top #(.EIGHT_CH(1'b1)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .sck(sck), .sdi(sdi),
		.sample_trigger(sample_trigger), .conv_done(conv_done), .channel_number_select(channel_number_select),
		.temp_convert(temp_convert), .filter_narrow(filter_narrow), .ref_int_en(ref_int_en),
		.ref_hi_level(ref_hi_level), .ref_buf_en(ref_buf_en), .thermo_en(thermo_en),
		.setup_echo_en(setup_echo_en), .converter_setup_word(converter_setup_word));
	// four-channel variant on the same link, so the ignored channel bit is exercised too
	acf_top #(.EIGHT_CH(1'b0)) dut_four (.clk_sys(clk_sys), .rst_b(rst_b), .sck(sck), .sdi(sdi),
		.sample_trigger(sample_trigger), .conv_done(conv_done), .channel_number_select(ch_four),
		.temp_convert(), .filter_narrow(), .ref_int_en(), .ref_hi_level(), .ref_buf_en(), .thermo_en(),
		.setup_echo_en(), .converter_setup_word());
	task automatic check(input logic [13:0] got, input logic [13:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// outputs settle one edge after the pulse, so sample after that edge
	task automatic pulse_done();
		@(posedge clk_sys);
		#1 conv_done = 1'b1;
		@(posedge clk_sys);
		#1 conv_done = 1'b0;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic load(input logic [13:0] w, input int nbits, input logic trig);
		@(posedge clk_sys);
		#1;
		host.send(w, nbits, trig);
		// the synchroniser needs a few cycles before the last edge counts
		repeat (4) @(posedge clk_sys);
		pulse_done();
	endtask
	initial begin
		#100000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		#1 rst_b = 1'b1;
		check(converter_setup_word, 14'h3FFF);
		check({4'h0, obs}, 14'h0004);
		$display("test reset done");
		foreach (rows[i]) begin
			load(rows[i].w, 14, 1'b0);
			check(converter_setup_word, rows[i].w);
			check({4'h0, obs}, {4'h0, rows[i].e});
			check({11'h0, ch_four}, {12'h0, rows[i].w[8:7]});
		end
		$display("test table done");
		load(14'h1C50, 14, 1'b0);
		load(14'h3EC0, 10, 1'b0);
		load(14'h3EC0, 14, 1'b1);
		check(converter_setup_word, 14'h3CB8);
		check({4'h0, obs}, 14'h00A5);
		$display("test refusals done");
		load(14'h3D45, 14, 1'b0);
		for (int i = 0; i < 3; i++) begin
			check({10'h0, channel_number_select, temp_convert}, 14'(i * 2));
			pulse_done();
		end
		check({13'h0, temp_convert}, 14'h0001);
		pulse_done();
		check({10'h0, channel_number_select, temp_convert}, 14'h0000);
		$display("test scan with thermometer done");
		load(14'h3CC7, 14, 1'b0);
		for (int i = 0; i < 3; i++) begin
			check({10'h0, channel_number_select, temp_convert}, 14'((i % 2) * 2));
			pulse_done();
		end
		$display("test scan loop done");
		// hold mode must keep stepping from where the scan stands, not restart at channel 0
		load(14'h3DC3, 14, 1'b0);
		check(converter_setup_word, 14'h3DC3);
		check({10'h0, channel_number_select, temp_convert}, 14'h0004);
		pulse_done();
		check({10'h0, channel_number_select, temp_convert}, 14'h0006);
		pulse_done();
		check({10'h0, channel_number_select, temp_convert}, 14'h0000);
		$display("test scan hold done");
		rst_b = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 rst_b = 1'b1;
		check(converter_setup_word, 14'h3FFF);
		check({4'h0, obs}, 14'h0004);
		check({11'h0, ch_four}, 14'h0000);
		load(rows[0].w, 14, 1'b0);
		check(converter_setup_word, rows[0].w);
		check({4'h0, obs}, {4'h0, rows[0].e});
		$display("test mid-run reset done");
		tally_and_finish();
	end
endmodule
